// File: pllds_div.sv
// Programmable divide-by-N counter stepping on a one-cycle strobe.
// Assumes the divide value is at least 1; 0 behaves as 1.
`timescale 1ns/10ps
module pllds_div #(
    parameter int W = 14
) (
    input  logic         sys_clk,
    input  logic         rst_n,
    input  logic         clear,
    input  logic         step,
    input  logic [W-1:0] div,
    output logic         last,
    output logic         pulse
);
    import pllds_pkg::*;

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         pulse_ff;
    logic         nxt_pulse;

    // Compare in W+1 bits so the top value does not wrap
    assign last = ({1'b0, cnt_ff} + {{W{1'b0}}, 1'b1}) >= {1'b0, div};

    always_comb
    begin
        nxt_cnt   = cnt_ff;
        nxt_pulse = 1'b0;
        if (clear)
        begin
            nxt_cnt = '0;
        end
        else if (step)
        begin
            nxt_cnt   = last ? '0 : W'(cnt_ff + 1'b1);
            nxt_pulse = last;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff   <= '0;
            pulse_ff <= 1'b0;
        end
        else
        begin
            cnt_ff   <= nxt_cnt;
            pulse_ff <= nxt_pulse;
        end
    end

    assign pulse = pulse_ff;

    property p_div_pulse;
        @(posedge sys_clk) disable iff (!rst_n)
        (step && last && !clear) |=> pulse ##1 !pulse;
    endproperty
    a_div_pulse: assert property (p_div_pulse)
        else $error("divider missed its output pulse");

    property p_div_quiet;
        @(posedge sys_clk) disable iff (!rst_n)
        !(step && last) |=> !pulse;
    endproperty
    a_div_quiet: assert property (p_div_quiet)
        else $error("divider pulsed early");
endmodule

// File: pllds_host.sv
// Host model that drives the three-wire serial load port.
// Assumes sys_clk at 100 MHz; each pin level is held for at least two cycles.
`timescale 1ns/10ps
module pllds_host (
    input  logic sys_clk,
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    initial
    begin
        serial_clk  = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    // ------------------------------------------------------------------
    // Word transfer
    // ------------------------------------------------------------------
    task automatic send(input logic [23:0] word);
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge sys_clk);
            serial_clk  <= 1'b0;
            serial_data <= word[i];
            repeat (2) @(posedge sys_clk);
            serial_clk <= 1'b1;
            repeat (1) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        serial_clk  <= 1'b0;
        // Released line shows the inverse, never the stale bit
        serial_data <= ~word[0];
        repeat (2) @(posedge sys_clk);
        load_strobe <= 1'b1;
        repeat (2) @(posedge sys_clk);
        load_strobe <= 1'b0;
    endtask
endmodule

// File: pllds_lock.sv
// Digital lock detector fed once per phase detector cycle.
// Assumes err_cyc holds that cycle's phase error in clock cycles.
`timescale 1ns/10ps
module pllds_lock (
    input  logic       sys_clk,
    input  logic       rst_n,
    input  logic       hold,
    input  logic       pd_done,
    input  logic [7:0] err_cyc,
    input  logic       lock_precision,
    output logic       locked
);
    import pllds_pkg::*;

    logic [2:0] good_ff;
    logic [2:0] nxt_good;
    logic       lock_ff;
    logic       nxt_lock;
    logic [2:0] need;

    assign need = lock_precision ? LOCK_NEED_FINE : LOCK_NEED_COARSE;

    always_comb
    begin
        nxt_good = good_ff;
        nxt_lock = lock_ff;
        if (hold)
        begin
            nxt_good = 3'h0;
            nxt_lock = 1'b0;
        end
        else if (pd_done)
        begin
            if (err_cyc < LOCK_ERR_CYC)
            begin
                // Saturate so a long good run cannot wrap
                nxt_good = (good_ff >= LOCK_NEED_FINE) ? good_ff
                                                       : 3'(good_ff + 3'h1);
                if (3'(good_ff + 3'h1) >= need)
                    nxt_lock = 1'b1;
            end
            else
            begin
                nxt_good = 3'h0;
            end
            if (err_cyc > UNLOCK_ERR_CYC)
                nxt_lock = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            good_ff <= 3'h0;
            lock_ff <= 1'b0;
        end
        else
        begin
            good_ff <= nxt_good;
            lock_ff <= nxt_lock;
        end
    end

    assign locked = lock_ff;

    property p_lock_three;
        @(posedge sys_clk) disable iff (!rst_n)
        ($rose(lock_ff) && !lock_precision) |-> $past(good_ff) >= 3'h2;
    endproperty
    a_lock_three: assert property (p_lock_three)
        else $error("lock set before three good cycles");

    property p_lock_five;
        @(posedge sys_clk) disable iff (!rst_n)
        ($rose(lock_ff) && lock_precision) |-> $past(good_ff) >= 3'h4;
    endproperty
    a_lock_five: assert property (p_lock_five)
        else $error("lock set before five good cycles");

    property p_unlock;
        @(posedge sys_clk) disable iff (!rst_n)
        (pd_done && err_cyc > UNLOCK_ERR_CYC) |=> !lock_ff;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("lock held through a large phase error");
endmodule

// File: pllds_pkg.sv
// Shared constants, latch layouts and helpers for the synthesizer core.
// Assumes a single 100 MHz system clock samples every pin.
package pllds_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int LOCK_ERR_NS    = 15;
    localparam int UNLOCK_ERR_NS  = 25;
    // Error below 15 ns: fewer cycles than this (least time, rounds up)
    localparam logic [7:0] LOCK_ERR_CYC =
        8'((LOCK_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Error above 25 ns: more cycles than this (rounds down)
    localparam logic [7:0] UNLOCK_ERR_CYC =
        8'(UNLOCK_ERR_NS / CLK_PERIOD_NS);
    localparam logic [2:0] LOCK_NEED_COARSE = 3'h3;
    localparam logic [2:0] LOCK_NEED_FINE   = 3'h5;

    // ------------------------------------------------------------------
    // Latch select codes and monitor codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_REF  = 2'h0;
    localparam logic [1:0] SEL_FB   = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;

    localparam logic [2:0] MON_TRISTATE = 3'h0;
    localparam logic [2:0] MON_DIG_LOCK = 3'h1;
    localparam logic [2:0] MON_FB_DIV   = 3'h2;
    localparam logic [2:0] MON_HIGH     = 3'h3;
    localparam logic [2:0] MON_REF_DIV  = 3'h4;
    localparam logic [2:0] MON_ANA_LOCK = 3'h5;
    localparam logic [2:0] MON_SER_DATA = 3'h6;
    localparam logic [2:0] MON_LOW      = 3'h7;

    // ------------------------------------------------------------------
    // Latch layouts, bit 23 first
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        rsvd;
        logic        delay_option;
        logic        sync;
        logic        lock_precision;
        logic [1:0]  test_bits;
        logic [1:0]  antibacklash_width;
        logic [13:0] ref_div;
        logic [1:0]  latch_sel;
    } pllds_ref_type;

    typedef struct packed {
        logic [1:0]  rsvd;
        logic        gain_bit;
        logic [12:0] main_div;
        logic [5:0]  swallow;
        logic [1:0]  latch_sel;
    } pllds_fb_type;

    typedef struct packed {
        logic [1:0]  prescaler_sel;
        logic        powerdown_ctl_hi;
        logic [13:0] pump_cfg;
        logic [2:0]  monitor_select;
        logic        powerdown_ctl_lo;
        logic        counter_reset;
        logic [1:0]  latch_sel;
    } pllds_func_type;

    localparam logic [23:0] REF_RST  = 24'h000004;
    localparam logic [23:0] FB_RST   = 24'h000301;
    localparam logic [23:0] FUNC_RST = 24'h000002;

    // Prescaler small modulus: 8, 16, 32 or 64
    function automatic logic [6:0] pres_base(input logic [1:0] sel);
        pres_base = 7'(7'h08 << sel);
    endfunction

    // Antibacklash hold time in clock cycles
    function automatic logic [1:0] abp_cycles(input logic [1:0] code);
        abp_cycles = (code == 2'h3) ? 2'h1 : 2'(code + 2'h1);
    endfunction

endpackage

// File: pllds_top.sv
// Synthesizer digital core: serial load port, latches, prescaler with
// swallow and main counters, reference divider, phase detector, monitor
// output and lock detect.
// Assumes all pins are synchronous to sys_clk and that serial clock,
// reference and RF inputs toggle no faster than every second cycle.
//
// Overview of operation
// - Prescaler modulus pair 8/9, 16/17, 32/33 or 64/65 from prescaler field.
// - Feedback division equals main value times modulus plus swallow value.
// - Main counter is 13 bits, values 3 to 8191; smaller not programmed.
// - Swallow counter is 6 bits, any value 0 to 63.
// - Reference divider is 14 bits, divides reference by 1 to 16383.
// - Phase detector compares divided reference with divided feedback.
// - Two-bit antibacklash field sets phase detector reset pulse width.
// - Monitor pin shows the signal chosen by three-bit monitor select.
// - Lock precision clear: lock after three cycles below 15 ns error.
// - Lock precision set: lock after five cycles below 15 ns error.
// - Lock stays high until one cycle shows error above 25 ns.
// - Analog lock mode: open-drain high when locked, narrow low pulses.
// - Shift 24-bit word on each serial clock rise, MSB first.
// - Load strobe rise copies shift register to latch chosen by DB1..DB0.
// - Select 0 reference, 1 feedback, 2 function, 3 initialization.
// - Reference latch: divide, antibacklash, test, precision, sync and delay.
// - Feedback latch holds swallow, main value and gain bit.
// - Chip enable low powers down and floats the charge pump.
`timescale 1ns/10ps
module pllds_top (
    input  logic sys_clk,
    input  logic rst_n,
    input  logic chip_enable,
    input  logic serial_clk,
    input  logic serial_data,
    input  logic load_strobe,
    input  logic ref_in,
    input  logic rf_in,
    output logic monitor_output,
    output logic monitor_output_oe,
    output logic pump_up,
    output logic pump_down,
    output logic pump_oe,
    output logic powered_down,
    output logic digital_lock
);
    import pllds_pkg::*;

    // ------------------------------------------------------------------
    // Input edge detection
    // ------------------------------------------------------------------
    logic sclk_q_ff;
    logic le_q_ff;
    logic refin_q_ff;
    logic rf_q_ff;
    logic sclk_rise;
    logic le_rise;
    logic ref_rise;
    logic rf_rise;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q_ff  <= 1'b0;
            le_q_ff    <= 1'b0;
            refin_q_ff <= 1'b0;
            rf_q_ff    <= 1'b0;
        end
        else
        begin
            sclk_q_ff  <= serial_clk;
            le_q_ff    <= load_strobe;
            refin_q_ff <= ref_in;
            rf_q_ff    <= rf_in;
        end
    end

    assign sclk_rise = serial_clk && !sclk_q_ff;
    assign le_rise   = load_strobe && !le_q_ff;
    assign ref_rise  = ref_in && !refin_q_ff;
    assign rf_rise   = rf_in && !rf_q_ff;

    // ------------------------------------------------------------------
    // Serial port and latches
    // ------------------------------------------------------------------
    logic [23:0]    shift_ff;
    logic [23:0]    nxt_shift;
    pllds_ref_type  ref_lat_ff;
    pllds_ref_type  nxt_ref_lat;
    pllds_fb_type   fb_lat_ff;
    pllds_fb_type   nxt_fb_lat;
    pllds_func_type fn_lat_ff;
    pllds_func_type nxt_fn_lat;

    always_comb
    begin
        nxt_shift   = shift_ff;
        nxt_ref_lat = ref_lat_ff;
        nxt_fb_lat  = fb_lat_ff;
        nxt_fn_lat  = fn_lat_ff;
        if (sclk_rise)
            nxt_shift = {shift_ff[22:0], serial_data};
        if (le_rise)
        begin
            case (shift_ff[1:0])
                SEL_REF:  nxt_ref_lat = pllds_ref_type'(shift_ff);
                SEL_FB:   nxt_fb_lat  = pllds_fb_type'(shift_ff);
                // Initialization shares the function layout here
                SEL_FUNC: nxt_fn_lat  = pllds_func_type'(shift_ff);
                SEL_INIT: nxt_fn_lat  = pllds_func_type'(shift_ff);
                default:  nxt_fn_lat  = fn_lat_ff;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_ff   <= 24'h000000;
            ref_lat_ff <= pllds_ref_type'(REF_RST);
            fb_lat_ff  <= pllds_fb_type'(FB_RST);
            fn_lat_ff  <= pllds_func_type'(FUNC_RST);
        end
        else
        begin
            shift_ff   <= nxt_shift;
            ref_lat_ff <= nxt_ref_lat;
            fb_lat_ff  <= nxt_fb_lat;
            fn_lat_ff  <= nxt_fn_lat;
        end
    end

    // ------------------------------------------------------------------
    // Power control
    // ------------------------------------------------------------------
    logic pd_ff;
    logic nxt_pd;
    logic hold;

    assign nxt_pd = !chip_enable || fn_lat_ff.powerdown_ctl_lo;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pd_ff <= 1'b1;
        else
            pd_ff <= nxt_pd;
    end

    // Counters are also cleared while software holds them in reset
    assign hold = pd_ff || fn_lat_ff.counter_reset;

    // ------------------------------------------------------------------
    // Prescaler and swallow counter
    // ------------------------------------------------------------------
    logic [6:0] pres_cnt_ff;
    logic [6:0] nxt_pres_cnt;
    logic [5:0] swal_ff;
    logic [5:0] nxt_swal;
    logic [6:0] cur_mod;
    logic       pres_pulse;
    logic       main_last;
    logic       fb_pulse;
    logic       ref_pulse;

    // Larger modulus while swallow count remains
    assign cur_mod = 7'(pres_base(fn_lat_ff.prescaler_sel)
                     + {6'h00, swal_ff != 6'h00});
    assign pres_pulse = rf_rise && (pres_cnt_ff == 7'(cur_mod - 7'h01));

    always_comb
    begin
        nxt_pres_cnt = pres_cnt_ff;
        nxt_swal     = swal_ff;
        if (hold)
        begin
            nxt_pres_cnt = 7'h00;
            nxt_swal     = fb_lat_ff.swallow;
        end
        else if (rf_rise)
        begin
            nxt_pres_cnt = pres_pulse ? 7'h00 : 7'(pres_cnt_ff + 7'h01);
            if (pres_pulse)
            begin
                // Reload together with the main counter wrap: N = B*P + A
                if (main_last)
                    nxt_swal = fb_lat_ff.swallow;
                else if (swal_ff != 6'h00)
                    nxt_swal = 6'(swal_ff - 6'h01);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pres_cnt_ff <= 7'h00;
            swal_ff     <= 6'h00;
        end
        else
        begin
            pres_cnt_ff <= nxt_pres_cnt;
            swal_ff     <= nxt_swal;
        end
    end

    // Main counter: values below 3 are the host's to avoid
    pllds_div #(.W(13)) u_main_div (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clear   (hold),
        .step    (pres_pulse),
        .div     (fb_lat_ff.main_div),
        .last    (main_last),
        .pulse   (fb_pulse)
    );

    pllds_div #(.W(14)) u_ref_div (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clear   (hold),
        .step    (ref_rise),
        .div     (ref_lat_ff.ref_div),
        .last    (),
        .pulse   (ref_pulse)
    );

    // ------------------------------------------------------------------
    // Phase detector
    // ------------------------------------------------------------------
    logic       up_ff;
    logic       nxt_up;
    logic       dn_ff;
    logic       nxt_dn;
    logic [1:0] abp_cnt_ff;
    logic [1:0] nxt_abp_cnt;
    logic [7:0] err_ff;
    logic [7:0] nxt_err;
    logic       pd_done;

    // Both flags set: hold them for the antibacklash width, then reset
    assign pd_done = up_ff && dn_ff
                     && (abp_cnt_ff
                         >= abp_cycles(ref_lat_ff.antibacklash_width));

    always_comb
    begin
        nxt_up      = up_ff;
        nxt_dn      = dn_ff;
        nxt_abp_cnt = abp_cnt_ff;
        nxt_err     = err_ff;
        if (hold)
        begin
            nxt_up      = 1'b0;
            nxt_dn      = 1'b0;
            nxt_abp_cnt = 2'h0;
            nxt_err     = 8'h00;
        end
        else if (pd_done)
        begin
            nxt_up      = ref_pulse;
            nxt_dn      = fb_pulse;
            nxt_abp_cnt = 2'h0;
            nxt_err     = 8'h00;
        end
        else
        begin
            if (ref_pulse)
                nxt_up = 1'b1;
            if (fb_pulse)
                nxt_dn = 1'b1;
            if (up_ff && dn_ff)
                nxt_abp_cnt = 2'(abp_cnt_ff + 2'h1);
            // Phase error: cycles with only one flag raised, saturating
            if ((up_ff != dn_ff) && (err_ff != 8'hFF))
                nxt_err = 8'(err_ff + 8'h01);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            up_ff      <= 1'b0;
            dn_ff      <= 1'b0;
            abp_cnt_ff <= 2'h0;
            err_ff     <= 8'h00;
        end
        else
        begin
            up_ff      <= nxt_up;
            dn_ff      <= nxt_dn;
            abp_cnt_ff <= nxt_abp_cnt;
            err_ff     <= nxt_err;
        end
    end

    assign pump_up   = up_ff;
    assign pump_down = dn_ff;
    assign pump_oe   = !pd_ff;

    pllds_lock u_lock (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .hold           (hold),
        .pd_done        (pd_done),
        .err_cyc        (err_ff),
        .lock_precision (ref_lat_ff.lock_precision),
        .locked         (digital_lock)
    );

    // ------------------------------------------------------------------
    // Monitor output
    // ------------------------------------------------------------------
    logic [2:0] msel;
    logic       mon_ff;
    logic       nxt_mon;

    assign msel = fn_lat_ff.monitor_select;

    always_comb
    begin
        case (msel)
            MON_DIG_LOCK: nxt_mon = digital_lock;
            MON_FB_DIV:   nxt_mon = fb_pulse;
            MON_HIGH:     nxt_mon = 1'b1;
            MON_REF_DIV:  nxt_mon = ref_pulse;
            MON_SER_DATA: nxt_mon = shift_ff[23];
            default:      nxt_mon = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mon_ff <= 1'b0;
        else
            mon_ff <= nxt_mon;
    end

    // Analog lock pulls low only while a pump flag is up; the pull-up
    // keeps the pin high in lock, so narrow low pulses remain
    assign monitor_output    = (msel == MON_ANA_LOCK) ? 1'b0 : mon_ff;
    assign monitor_output_oe = (msel == MON_ANA_LOCK) ? (up_ff || dn_ff)
                             : (msel != MON_TRISTATE);
    assign powered_down      = pd_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_shift;
        @(posedge sys_clk) disable iff (!rst_n)
        sclk_rise |=> shift_ff == {$past(shift_ff[22:0]), $past(serial_data)};
    endproperty
    a_shift: assert property (p_shift)
        else $error("serial bit not shifted in");

    property p_load_ref;
        @(posedge sys_clk) disable iff (!rst_n)
        (le_rise && shift_ff[1:0] == SEL_REF)
        |=> ref_lat_ff == $past(shift_ff) && $stable(fb_lat_ff);
    endproperty
    a_load_ref: assert property (p_load_ref)
        else $error("reference latch not loaded");

    property p_load_fb;
        @(posedge sys_clk) disable iff (!rst_n)
        (le_rise && shift_ff[1:0] == SEL_FB)
        |=> fb_lat_ff == $past(shift_ff) && $stable(ref_lat_ff);
    endproperty
    a_load_fb: assert property (p_load_fb)
        else $error("feedback latch not loaded");

    property p_swallow_mod;
        @(posedge sys_clk) disable iff (!rst_n)
        (pres_pulse && swal_ff != 6'h00)
        |-> pres_cnt_ff == pres_base(fn_lat_ff.prescaler_sel);
    endproperty
    a_swallow_mod: assert property (p_swallow_mod)
        else $error("swallow phase not using the larger modulus");

    property p_reload;
        @(posedge sys_clk) disable iff (!rst_n)
        (!hold && pres_pulse && main_last)
        |=> swal_ff == $past(fb_lat_ff.swallow);
    endproperty
    a_reload: assert property (p_reload)
        else $error("swallow count not reloaded at main wrap");

    property p_pfd_up;
        @(posedge sys_clk) disable iff (!rst_n)
        (ref_pulse && !hold) |=> up_ff;
    endproperty
    a_pfd_up: assert property (p_pfd_up)
        else $error("reference edge did not raise pump up");

    property p_abp;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(up_ff && dn_ff) |-> ##[1:4] !(up_ff && dn_ff);
    endproperty
    a_abp: assert property (p_abp)
        else $error("antibacklash reset too long");

    property p_power;
        @(posedge sys_clk) disable iff (!rst_n)
        !chip_enable |=> !pump_oe && powered_down;
    endproperty
    a_power: assert property (p_power)
        else $error("pump still driven with chip disabled");

    property p_mon_lock;
        @(posedge sys_clk) disable iff (!rst_n)
        (msel == MON_DIG_LOCK && $stable(msel))
        |-> monitor_output == $past(digital_lock);
    endproperty
    a_mon_lock: assert property (p_mon_lock)
        else $error("monitor does not follow lock detect");

    property p_ana_lock;
        @(posedge sys_clk) disable iff (!rst_n)
        (msel == MON_ANA_LOCK)
        |-> (monitor_output_oe == (up_ff || dn_ff)) && !monitor_output;
    endproperty
    a_ana_lock: assert property (p_ana_lock)
        else $error("analog lock output misdriven");
endmodule

// File: tb_pllds_top.sv
// Self-checking bench for the synthesizer core.
// Assumes the host model drives the serial pins; inputs move at posedge.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_pllds_top;
    import pllds_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, chip_enable = 1'b1;
    logic ref_in = 1'b0, rf_in = 1'b0, sck, sda, lstb;
    logic mon, mon_oe, up, dn, p_oe, pdn, dlock;
    logic [1:0] tg = 2'h0;
    logic [31:0] seed = 32'h43D90E29;
    int n_mismatch = 0, cmp_count = 0, n, p, a, b, r, lp;
    logic [23:0] tw [5];
    logic [1:0]  te [5];
    always #5 sys_clk = ~sys_clk;
    // Inputs toggle every second cycle, so one period is four cycles
    always @(posedge sys_clk)
    begin
        tg <= tg + 2'h1;
        ref_in <= tg[0] ? ~ref_in : ref_in;
        // Slow RF keeps the prescaler output far below its limit
        rf_in  <= tg[0] ? ~rf_in : rf_in;
    end
    pllds_host pllds_host_inst (.sys_clk(sys_clk), .serial_clk(sck),
        .serial_data(sda), .load_strobe(lstb));
    pllds_top pllds_top_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .chip_enable(chip_enable), .serial_clk(sck), .serial_data(sda),
        .load_strobe(lstb), .ref_in(ref_in), .rf_in(rf_in),
        .monitor_output(mon), .monitor_output_oe(mon_oe), .pump_up(up),
        .pump_down(dn), .pump_oe(p_oe), .powered_down(pdn),
        .digital_lock(dlock));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [23:0] fw(input logic [1:0] ps, input logic [2:0] m,
                             input logic [1:0] sel);
        return {ps, 15'h0000, m, 2'h0, sel};
    endfunction
    task automatic wrap_up();
        $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Cycles between two rises of the monitor pin, bounded
    task automatic gap(output int g);
        int c;
        logic prev, st;
        c = 0; g = 0; prev = 1'b1; st = 1'b0;
        for (int i = 0; i < 4000 && g == 0; i++)
        begin
            @(negedge sys_clk);
            c++;
            if (mon === 1'b1 && prev === 1'b0)
            begin
                if (st) g = c;
                st = 1'b1;
                c = 0;
            end
            prev = mon;
        end
        if (g == 0)
        begin
            n_mismatch++;
            wrap_up();
        end
    endtask
    // Waits for the lock pin to reach a level; a timeout is a mismatch
    task automatic wait_lock(input logic lv);
        for (int i = 0; i < 3000 && dlock !== lv; i++)
            @(negedge sys_clk);
        if (dlock !== lv)
        begin
            n_mismatch++;
            wrap_up();
        end
    endtask
    initial
    begin
        tw = '{fw(0, MON_HIGH, SEL_FUNC), fw(0, MON_LOW, SEL_FUNC),
               fw(0, MON_TRISTATE, SEL_FUNC), fw(2, MON_SER_DATA, SEL_FUNC),
               fw(0, MON_HIGH, SEL_INIT)};
        te = '{2'h3, 2'h2, 2'h0, 2'h3, 2'h3};
        @(negedge sys_clk);
        `CHK({pdn, dlock, p_oe}, 3'h4)
        @(posedge sys_clk);
        @(posedge sys_clk) rst_n <= 1'b1;
        repeat (2) @(negedge sys_clk);
        `CHK(pdn, 1'b0)
        $display("test reset done");
        for (int k = 0; k < 5; k++)
        begin
            pllds_host_inst.send(tw[k]);
            repeat (4) @(negedge sys_clk);
            `CHK({mon_oe, mon & mon_oe}, te[k])
        end
        $display("test monitor done");
        for (int k = 0; k < 4; k++)
        begin
            p = k; a = rnd() % 4; b = 3 + rnd() % 2;
            pllds_host_inst.send({3'h0, 13'(b), 6'(a), SEL_FB});
            pllds_host_inst.send(fw(2'(p), MON_FB_DIV, SEL_FUNC));
            gap(n);
            `CHK(n, 4 * (b * (8 << p) + a))
        end
        $display("test feedback done");
        r = 1 + rnd() % 8;
        pllds_host_inst.send({8'h00, 14'(r), SEL_REF});
        pllds_host_inst.send(fw(0, MON_REF_DIV, SEL_FUNC));
        gap(n);
        `CHK(n, 4 * r)
        $display("test reference done");
        lp = rnd() % 2;
        pllds_host_inst.send({3'h0, 13'h0003, 6'h00, SEL_FB});
        pllds_host_inst.send({3'h0, 1'(lp), 4'h0, 14'h0018, SEL_REF});
        // Counter reset aligns both dividers; R equals N so phases match
        pllds_host_inst.send(fw(0, MON_DIG_LOCK, SEL_FUNC) | 24'h000004);
        pllds_host_inst.send(fw(0, MON_DIG_LOCK, SEL_FUNC));
        @(negedge sys_clk);
        `CHK(dlock, 1'b0)
        wait_lock(1'b1);
        repeat (2) @(negedge sys_clk);
        `CHK({mon, mon_oe, up ^ dn, dlock}, 4'hD)
        pllds_host_inst.send(fw(0, MON_ANA_LOCK, SEL_FUNC));
        pllds_host_inst.send({3'h0, 1'(lp), 4'h0, 14'h0019, SEL_REF});
        wait_lock(1'b0);
        `CHK({mon, dlock}, 2'h0)
        $display("test lock done");
        @(posedge sys_clk) chip_enable <= 1'b0;
        repeat (3) @(negedge sys_clk);
        `CHK({pdn, p_oe}, 2'h2)
        @(posedge sys_clk) chip_enable <= 1'b1;
        repeat (3) @(negedge sys_clk);
        `CHK(pdn, 1'b0)
        $display("test power done");
        wrap_up();
    end
endmodule
